/* rtl/obc_params.svh */
`ifndef OBC_PARAMS_SVH
`define OBC_PARAMS_SVH

// Word index = byte offset / 4; channel n sits at words n*8 .. n*8+7
`define OBC_G_MODE    3'h0
`define OBC_G_STATUS  3'h1
`define OBC_G_IRQ_EN  3'h2
`define OBC_G_IRQ_CLR 3'h3
`define OBC_G_HALT    3'h4
`define OBC_G_TIMER   3'h5
`define OBC_G_CHCLR   3'h6
`define OBC_G_SEQ     3'h7

`define OBC_C_ADDR    3'h0
`define OBC_C_AMASK   3'h1
`define OBC_C_DATA    3'h2
`define OBC_C_DMASK   3'h3
`define OBC_C_CTRL    3'h4
`define OBC_C_COUNT   3'h5

// Mode register fields
`define OBC_MODE_SEL   1:0
`define OBC_MODE_SHORT 2
`define OBC_MODE_PAIR  3
`define OBC_MODE_RSTCH 7:4
`define OBC_MODE_WMASK 32'h0000_00ff
`define OBC_MODE_RST   32'h0000_0000

// Channel control fields
`define OBC_CT_EN     0
`define OBC_CT_UADDR  1
`define OBC_CT_AMSK   2
`define OBC_CT_UDATA  3
`define OBC_CT_DMSK   4
`define OBC_CT_SIZE   6:5
`define OBC_CT_UTYPE  7
`define OBC_CT_TYPE   9:8
`define OBC_CT_USTATE 10
`define OBC_CT_STATE  12:11
`define OBC_CT_URW    13
`define OBC_CT_RD     14
`define OBC_CT_UCNT   15
`define OBC_CT_ACT    17:16
`define OBC_CT_WMASK  32'h0003_ffff
`define OBC_CT_RST    32'h0000_0000

// Count field
`define OBC_CNT_W     16
`define OBC_CNT_RST   16'h0001

// Status bits
`define OBC_ST_BRK    0
`define OBC_ST_TRIG   1
`define OBC_ST_TIME   2
`define OBC_ST_SEQ    3
`define OBC_ST_W      4

// Halt register bits and channel-clear all bit
`define OBC_H_HALTED  0
`define OBC_H_BEFORE  1
`define OBC_CHCLR_ALL 31

`endif

/* rtl/obc_pkg.sv */
`include "obc_params.svh"

package obc_pkg;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic [1:0]  size;
    logic        rd;
    logic [1:0]  atype;
    logic [1:0]  bstate;
  } obc_bus_s;

  typedef struct packed {
    logic [31:0]           addr;
    logic [31:0]           amask;
    logic [31:0]           data;
    logic [31:0]           dmask;
    logic [31:0]           ctrl;
    logic [`OBC_CNT_W-1:0] count;
  } obc_cfg_s;

  typedef enum logic [1:0] {OBC_SZ_BYTE, OBC_SZ_WORD, OBC_SZ_LONG} obc_size_e;
  typedef enum logic [1:0] {OBC_MD_NORMAL, OBC_MD_SEQ, OBC_MD_RANGE, OBC_MD_TIME} obc_mode_e;
  typedef enum logic [1:0] {OBC_ACT_AFTER, OBC_ACT_BEFORE, OBC_ACT_TRIG} obc_act_e;
  typedef enum logic [1:0] {OBC_HS_RUN, OBC_HS_PEND, OBC_HS_HALT} obc_halt_e;

  function automatic logic [31:0] obc_size_mask(input logic [1:0] s);
    obc_size_mask = (s == OBC_SZ_BYTE) ? 32'h0000_00ff :
                    (s == OBC_SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction

  function automatic obc_act_e obc_act(input obc_cfg_s c);
    obc_act = obc_act_e'(c.ctrl[`OBC_CT_ACT]);
  endfunction

endpackage

/* rtl/obc_channel.sv */
`timescale 1ns/1ns
`include "obc_params.svh"

module obc_channel
  import obc_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst,
  // Observed bus and setup
  input  wire obc_bus_s bus,
  input  wire obc_cfg_s cfg,
  input  wire logic     arm,
  input  wire logic     clr,
  // Results
  output logic          rest_ok,
  output logic          sat
);

  logic [`OBC_CNT_W-1:0] cnt;

  wire [31:0] am = cfg.ctrl[`OBC_CT_AMSK] ? cfg.amask : 32'h0000_0000;
  wire [31:0] dm = cfg.ctrl[`OBC_CT_DMSK] ? cfg.dmask : 32'h0000_0000;
  wire [31:0] sm = obc_size_mask(cfg.ctrl[`OBC_CT_SIZE]);

  wire addr_ok = !cfg.ctrl[`OBC_CT_UADDR] || (((bus.addr ^ cfg.addr) & ~am) == 32'h0);
  wire data_ok = !cfg.ctrl[`OBC_CT_UDATA] ||
                 ((bus.size == cfg.ctrl[`OBC_CT_SIZE]) &&
                  (((bus.data ^ cfg.data) & sm & ~dm) == 32'h0));
  wire type_ok = !cfg.ctrl[`OBC_CT_UTYPE] || (bus.atype == cfg.ctrl[`OBC_CT_TYPE]);
  wire st_ok   = !cfg.ctrl[`OBC_CT_USTATE] || (bus.bstate == cfg.ctrl[`OBC_CT_STATE]);
  wire rw_ok   = !cfg.ctrl[`OBC_CT_URW] || (bus.rd == cfg.ctrl[`OBC_CT_RD]);

  assign rest_ok = bus.valid && arm && cfg.ctrl[`OBC_CT_EN] && data_ok && type_ok && st_ok
                   && rw_ok;
  wire hit = rest_ok && addr_ok;

  wire [`OBC_CNT_W-1:0] target = (!cfg.ctrl[`OBC_CT_UCNT] || cfg.count == '0) ?
                                 `OBC_CNT_RST : cfg.count;
  wire [`OBC_CNT_W:0]   inc    = {1'b0, cnt} + {{`OBC_CNT_W{1'b0}}, 1'b1};
  wire                  last   = inc >= {1'b0, target};
  assign sat = hit && last;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0;
    end else if (hit) begin
      cnt <= last ? '0 : inc[`OBC_CNT_W-1:0];
    end
  end

endmodule // obc_channel

/* rtl/obc_timer.sv */
`timescale 1ns/1ns

module obc_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         start,
  input  wire logic         stop,
  // Result
  output logic [W-1:0]      value,
  output logic              done
);

  logic         running;
  logic [W-1:0] cnt;

  assign done = stop && running;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running <= 1'b0;
      cnt     <= '0;
      value   <= '0;
    end else if (done) begin
      running <= 1'b0;
      value   <= cnt;
    end else if (start) begin
      running <= 1'b1;
      cnt     <= '0;
    end else if (running) begin
      cnt     <= cnt + 1'b1;
    end
  end

endmodule // obc_timer

/* rtl/obc_top.sv */
// What this block does
// - Compare bus address with programmed value; masked bits always match.
// - Address condition set to ignore places no address restriction.
// - Optional data compare with bit mask; ignore removes data condition.
// - Data compare only matches accesses of the selected size.
// - Access type, bus state and direction qualifiers, state and direction ignorable.
// - Count satisfactions, act at programmed count; counting off means count one.
// - A satisfied break channel halts program execution.
// - After-execution halt waits until the matching instruction completes.
// - Before-execution halt stops before the matching instruction runs.
// - Trigger action pulses a trigger output instead of halting.
// - Sequential mode chains channels in ascending order up to 8.
// - Chain is 1 to 8 or 5 to 8; others except the reset channel idle meanwhile.
// - Designated reset channel restarts sequence progress from first step.
// - Range mode pairs 9 with 10 or 11 with 12 as bounds.
// - Time mode starts timer on channel 7, captures on channel 8.
// - Matching only observes the bus and never alters memory.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "obc_params.svh"

module obc_top
  import obc_pkg::*;
#(
  parameter int TIMER_W = 32
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Observed CPU bus
  input  wire obc_bus_s    cpu_bus,
  input  wire logic        insn_done,
  // Debug outputs
  output logic             halt_req,
  output logic             halt_before,
  output logic             trig_out,
  output logic             irq
);

  generate
    if (TIMER_W < 8 || TIMER_W > 32) begin : g_chk
      $error("TIMER_W must be 8 to 32");
    end
  endgenerate

  // Register storage
  obc_cfg_s             cfg [1:12];
  logic [7:0]           mode_r;
  logic [`OBC_ST_W-1:0] status;
  logic [`OBC_ST_W-1:0] irq_en;
  logic [2:0]           seq_step;
  obc_halt_e            hs;

  // Bus access decode
  wire        wr     = avs_write && !avs_waitrequest;
  wire [3:0]  a_ch   = avs_address[6:3];
  wire [2:0]  a_r    = avs_address[2:0];
  wire        a_glob = (a_ch == 4'h0);
  wire        a_chok = (a_ch >= 4'h1) && (a_ch <= 4'hc);
  wire [3:0]  a_idx  = a_chok ? a_ch : 4'h1;
  wire [31:0] wd     = avs_writedata;
  wire        gw     = wr && a_glob;

  wire        w_mode  = gw && (a_r == `OBC_G_MODE);
  wire        w_irqen = gw && (a_r == `OBC_G_IRQ_EN);
  wire        w_iclr  = gw && (a_r == `OBC_G_IRQ_CLR);
  wire        w_halt  = gw && (a_r == `OBC_G_HALT);
  wire        w_chclr = gw && (a_r == `OBC_G_CHCLR);

  // Mode decode
  wire obc_mode_e mode   = obc_mode_e'(mode_r[`OBC_MODE_SEL]);
  wire            m_norm = (mode == OBC_MD_NORMAL);
  wire            m_seq  = (mode == OBC_MD_SEQ);
  wire            m_rng  = (mode == OBC_MD_RANGE);
  wire            m_time = (mode == OBC_MD_TIME);
  wire [3:0]      first  = mode_r[`OBC_MODE_SHORT] ? 4'h5 : 4'h1;
  wire [3:0]      rst_ch = mode_r[`OBC_MODE_RSTCH];
  wire [3:0]      lo_ch  = mode_r[`OBC_MODE_PAIR] ? 4'hb : 4'h9;
  wire [3:0]      hi_ch  = lo_ch + 4'h1;
  wire [3:0]      exp_ch = first + {1'b0, seq_step};

  // Channel results
  logic [12:1] rest;
  logic [12:1] sat;
  logic [12:1] fire;
  logic [12:1] f_before;
  logic [12:1] f_after;
  logic [12:1] f_trig;

  generate
    for (genvar k = 1; k <= 12; k++) begin : g_ch
      wire sel    = wr && (a_ch == 4'(k));
      wire clr_me = w_chclr && (wd[`OBC_CHCLR_ALL] || wd[k-1]);
      wire in_ch  = (4'(k) >= first) && (k <= 8);
      wire arm    = !m_seq || in_ch || (rst_ch == 4'(k));
      wire pair   = (4'(k) == lo_ch) || (4'(k) == hi_ch);
      wire tpair  = (k == 7) || (k == 8);

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cfg[k].addr  <= 32'h0000_0000;
          cfg[k].amask <= 32'h0000_0000;
          cfg[k].data  <= 32'h0000_0000;
          cfg[k].dmask <= 32'h0000_0000;
          cfg[k].ctrl  <= `OBC_CT_RST;
          cfg[k].count <= `OBC_CNT_RST;
        end else if (clr_me) begin
          cfg[k].addr  <= 32'h0000_0000;
          cfg[k].amask <= 32'h0000_0000;
          cfg[k].data  <= 32'h0000_0000;
          cfg[k].dmask <= 32'h0000_0000;
          cfg[k].ctrl  <= `OBC_CT_RST;
          cfg[k].count <= `OBC_CNT_RST;
        end else if (sel) begin
          case (a_r)
            `OBC_C_ADDR:  cfg[k].addr  <= wd;
            `OBC_C_AMASK: cfg[k].amask <= wd;
            `OBC_C_DATA:  cfg[k].data  <= wd;
            `OBC_C_DMASK: cfg[k].dmask <= wd;
            `OBC_C_CTRL:  cfg[k].ctrl  <= wd & `OBC_CT_WMASK;
            `OBC_C_COUNT: cfg[k].count <= wd[`OBC_CNT_W-1:0];
            default: ;
          endcase
        end
      end

      obc_channel u_ch (
        .clk     (clk),
        .rst     (rst),
        .bus     (cpu_bus),
        .cfg     (cfg[k]),
        .arm     (arm),
        .clr     (clr_me || sel),
        .rest_ok (rest[k]),
        .sat     (sat[k])
      );

      // Individual actions per mode
      assign fire[k] = sat[k] && (m_norm || (m_rng && !pair) || (m_time && !tpair));
      assign f_before[k] = fire[k] && (obc_act(cfg[k]) == OBC_ACT_BEFORE);
      assign f_after[k]  = fire[k] && (obc_act(cfg[k]) == OBC_ACT_AFTER);
      assign f_trig[k]   = fire[k] && (obc_act(cfg[k]) == OBC_ACT_TRIG);
    end
  endgenerate

  wire       rst_hit  = m_seq && (rst_ch >= 4'h1) && (rst_ch <= 4'hc) && sat[rst_ch];
  wire       seq_adv  = m_seq && !rst_hit && (exp_ch <= 4'h8) && sat[exp_ch];
  wire       seq_done = seq_adv && (exp_ch == 4'h8);
  wire [2:0] next_seq_step = rst_hit  ? 3'h0 :
                             seq_done ? 3'h0 :
                             seq_adv  ? seq_step + 3'h1 : seq_step;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_step <= 3'h0;
    end else if (!m_seq) begin
      seq_step <= 3'h0;
    end else begin
      seq_step <= next_seq_step;
    end
  end

  wire rng_hit = m_rng && rest[lo_ch] && (cpu_bus.addr >= cfg[lo_ch].addr) &&
                 (cpu_bus.addr <= cfg[hi_ch].addr);

  // Composite events take the action of the deciding channel
  wire obc_act_e seq_act = obc_act(cfg[8]);
  wire obc_act_e rng_act = obc_act(cfg[lo_ch]);

  wire ev_before = (|f_before) || (seq_done && seq_act == OBC_ACT_BEFORE) ||
                   (rng_hit && rng_act == OBC_ACT_BEFORE);
  wire ev_after  = (|f_after) || (seq_done && seq_act == OBC_ACT_AFTER) ||
                   (rng_hit && rng_act == OBC_ACT_AFTER);
  wire ev_trig   = (|f_trig) || (seq_done && seq_act == OBC_ACT_TRIG) ||
                   (rng_hit && rng_act == OBC_ACT_TRIG);

  logic [TIMER_W-1:0] t_value;
  logic               t_done;

  obc_timer #(
    .W (TIMER_W)
  ) u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (m_time && sat[7]),
    .stop  (m_time && sat[8]),
    .value (t_value),
    .done  (t_done)
  );

  // Halt sequencing
  // host release write
  wire       release_h = w_halt && wd[`OBC_H_HALTED];
  obc_halt_e next_hs;
  logic      next_before;

  always_comb begin
    next_hs     = hs;
    next_before = halt_before;
    case (hs)
      OBC_HS_RUN: begin
        if (ev_before) begin
          next_hs     = OBC_HS_HALT;
          next_before = 1'b1;
        end else if (ev_after) begin
          next_hs     = OBC_HS_PEND;
        end
      end
      OBC_HS_PEND: begin
        if (ev_before) begin
          next_hs     = OBC_HS_HALT;
          next_before = 1'b1;
        end else if (insn_done) begin
          next_hs     = OBC_HS_HALT;
          next_before = 1'b0;
        end
      end
      OBC_HS_HALT: begin
        if (release_h) begin
          next_hs     = OBC_HS_RUN;
          next_before = 1'b0;
        end
      end
      default: begin
        next_hs     = OBC_HS_RUN;
        next_before = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs          <= OBC_HS_RUN;
      halt_req    <= 1'b0;
      halt_before <= 1'b0;
    end else begin
      hs          <= next_hs;
      halt_req    <= (next_hs == OBC_HS_HALT);
      halt_before <= next_before;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_out <= 1'b0;
    end else begin
      trig_out <= ev_trig;
    end
  end

  // Sticky status, set wins over clear
  wire                 enter_h = (hs != OBC_HS_HALT) && (next_hs == OBC_HS_HALT);
  wire [`OBC_ST_W-1:0] ev_set  = {seq_adv, t_done, ev_trig, enter_h};
  wire [`OBC_ST_W-1:0] st_clr  = w_iclr ? wd[`OBC_ST_W-1:0] : '0;
  wire [`OBC_ST_W-1:0] next_status = (status & ~st_clr) | ev_set;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & irq_en);
    end
  end

  // Global registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= 8'(`OBC_MODE_RST);
      irq_en <= '0;
    end else begin
      if (w_mode) begin
        mode_r <= wd[7:0];
      end
      if (w_irqen) begin
        irq_en <= wd[`OBC_ST_W-1:0];
      end
    end
  end

  // Read selection
  wire obc_cfg_s c_rd = cfg[a_idx];
  wire [31:0] ch_rd =
    (a_r == `OBC_C_ADDR)  ? c_rd.addr  :
    (a_r == `OBC_C_AMASK) ? c_rd.amask :
    (a_r == `OBC_C_DATA)  ? c_rd.data  :
    (a_r == `OBC_C_DMASK) ? c_rd.dmask :
    (a_r == `OBC_C_CTRL)  ? c_rd.ctrl  :
    (a_r == `OBC_C_COUNT) ? {{(32-`OBC_CNT_W){1'b0}}, c_rd.count} : 32'h0000_0000;
  wire [31:0] gl_rd =
    (a_r == `OBC_G_MODE)   ? {24'h00_0000, mode_r} :
    (a_r == `OBC_G_STATUS) ? {{(32-`OBC_ST_W){1'b0}}, status} :
    (a_r == `OBC_G_IRQ_EN) ? {{(32-`OBC_ST_W){1'b0}}, irq_en} :
    (a_r == `OBC_G_HALT)   ? {30'h0, halt_before, halt_req} :
    (a_r == `OBC_G_TIMER)  ? 32'(t_value) :
    (a_r == `OBC_G_SEQ)    ? {29'h0, seq_step} : 32'h0000_0000;
  wire [31:0] rd_mux = a_glob ? gl_rd : a_chok ? ch_rd : 32'h0000_0000;

  // One wait cycle, then the access completes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : avs_readdata;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // observation only, no path toward memory

endmodule // obc_top

/* sim/obc_top_props.sv */
`timescale 1ns/1ns

module obc_top_props
  import obc_pkg::*;
#(
  parameter int TIMER_W = 32
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register bus
  input wire logic [6:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Observed bus
  input wire obc_bus_s    cpu_bus,
  input wire logic        insn_done,
  // Debug outputs
  input wire logic        halt_req,
  input wire logic        halt_before,
  input wire logic        trig_out,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire rel_wr = avs_write && !avs_waitrequest && avs_address == 7'h04 && avs_writedata[0];

  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest not low one cycle after request");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without request");
  a_trig_single: assert property (trig_out |=> !trig_out)
    else $error("trigger pulse longer than one cycle");
  a_trig_cause: assert property ($rose(trig_out) |-> $past(cpu_bus.valid))
    else $error("trigger without bus access");
  a_halt_hold: assert property (halt_req && !rel_wr |=> halt_req)
    else $error("halt dropped without release");
  a_before_bus: assert property ($rose(halt_req) && halt_before |-> $past(cpu_bus.valid))
    else $error("before halt not right after bus match");
  a_after_insn: assert property ($rose(halt_req) && !halt_before |-> $past(insn_done))
    else $error("after halt not right after completion");
endmodule // obc_top_props

bind obc_top obc_top_props #(.TIMER_W(TIMER_W)) u_props (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cpu_bus(cpu_bus), .insn_done(insn_done),
  .halt_req(halt_req), .halt_before(halt_before), .trig_out(trig_out), .irq(irq)
);

/* sim/obc_cpu_model.sv */
`timescale 1ns/1ns

module obc_cpu_model
  import obc_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Bus seen by the break block
  output obc_bus_s  cpu_bus,
  output logic      insn_done
);
  initial begin
    cpu_bus = '0;
    insn_done = 1'b0;
  end

  task automatic access(input logic [31:0] a, input logic [31:0] d, input logic [1:0] sz,
                        input logic rd);
    access_q(a, d, sz, rd, 2'h0, 2'h0);
  endtask

  task automatic access_q(input logic [31:0] a, input logic [31:0] d, input logic [1:0] sz,
                          input logic rd, input logic [1:0] at, input logic [1:0] bs);
    @(posedge clk);
    cpu_bus <= '{1'b1, a, d, sz, rd, at, bs};
    @(posedge clk);
    // Released bus shows inverted lines except size, which is kept
    cpu_bus <= '{1'b0, ~a, ~d, sz, ~rd, ~at, ~bs};
  endtask

  task automatic finish_insn();
    @(posedge clk);
    insn_done <= 1'b1;
    @(posedge clk);
    insn_done <= 1'b0;
  endtask
endmodule // obc_cpu_model

/* sim/onchip_break_comparator_tb.sv */
`timescale 1ns/1ns

module onchip_break_comparator_tb
  import obc_pkg::*;
;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest;
  logic        insn_done, halt_req, halt_before, trig_out, irq;
  logic [6:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdq;
  obc_bus_s    cpu_bus;
  int          n_errors = 0;
  int          n_checks = 0;

  obc_top DUT (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_bus(cpu_bus), .insn_done(insn_done),
    .halt_req(halt_req), .halt_before(halt_before), .trig_out(trig_out), .irq(irq)
  );
  obc_cpu_model cpu (.clk(clk), .cpu_bus(cpu_bus), .insn_done(insn_done));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic outs(input string what, input logic [2:0] exp);
    #1;
    chk(what, {29'h0, exp}, {29'h0, halt_req, halt_before, trig_out});
  endtask

  task automatic bus_op(input logic wr, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rdq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  function automatic logic [6:0] ch(input int n, input int r);
    return 7'(n * 8 + r);
  endfunction

  task automatic clean();
    bus_op(1'b1, 7'h04, 32'h1);
    bus_op(1'b1, 7'h03, 32'hf);
    bus_op(1'b1, 7'h06, 32'h8000_0000);
    bus_op(1'b1, 7'h00, 32'h0);
  endtask

  task automatic t_regs();
    bus_op(1'b0, ch(1, 5), 32'h0);
    chk("count_reset", 32'h1, rdq);
    bus_op(1'b1, ch(1, 4), 32'hffff_ffff);
    bus_op(1'b0, ch(1, 4), 32'h0);
    chk("ctrl_bits", 32'h0003_ffff, rdq);
    bus_op(1'b1, ch(12, 0), 32'h1234_5678);
    bus_op(1'b0, ch(12, 0), 32'h0);
    chk("ch12_addr", 32'h1234_5678, rdq);
    bus_op(1'b1, 7'h68, 32'h5);
    bus_op(1'b0, 7'h68, 32'h0);
    chk("unmapped", 32'h0, rdq);
    clean();
    $display("test regs done");
  endtask

  task automatic t_before();
    bus_op(1'b1, 7'h02, 32'h1);
    bus_op(1'b1, ch(1, 0), 32'h0000_1000);
    bus_op(1'b1, ch(1, 1), 32'h0000_000f);
    bus_op(1'b1, ch(1, 4), 32'h0001_0007);
    cpu.access(32'h0000_2000, 32'h0, OBC_SZ_LONG, 1'b1);
    outs("miss", 3'b000);
    cpu.access(32'h0000_100c, 32'h0, OBC_SZ_LONG, 1'b1);
    outs("before", 3'b110);
    chk("irq_set", 32'h1, {31'h0, irq});
    bus_op(1'b0, 7'h01, 32'h0);
    chk("status", 32'h1, rdq);
    bus_op(1'b1, 7'h04, 32'h1);
    bus_op(1'b1, 7'h03, 32'h1);
    @(posedge clk);
    #1;
    chk("irq_clr", 32'h0, {31'h0, irq});
    outs("release", 3'b000);
    clean();
    $display("test before done");
  endtask

  task automatic t_trig();
    logic [31:0] dv[8] = '{32'hab, 32'hab, 32'hab, 32'hac, 32'hab, 32'hab, 32'hab, 32'hab};
    logic [1:0]  sv[8] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
    logic        rv[8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [1:0]  tv[8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
    logic [1:0]  bv[8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0, 2'h0};
    bus_op(1'b1, 7'h02, 32'h1);
    bus_op(1'b1, ch(2, 2), 32'h0000_00ab);
    bus_op(1'b1, ch(2, 5), 32'h3);
    bus_op(1'b1, ch(2, 4), 32'h0002_e489);
    for (int i = 0; i < 8; i++) begin
      cpu.access_q(32'(i) * 32'h40, dv[i], sv[i], rv[i], tv[i], bv[i]);
      outs("trig", {2'b00, i == 7});
    end
    chk("irq_masked", 32'h0, {31'h0, irq});
    bus_op(1'b0, 7'h01, 32'h0);
    chk("status_trig", 32'h2, rdq);
    clean();
    $display("test trig done");
  endtask

  task automatic t_after();
    bus_op(1'b1, ch(3, 0), 32'h0000_3000);
    bus_op(1'b1, ch(3, 5), 32'h5);
    bus_op(1'b1, ch(3, 4), 32'h3);
    cpu.access(32'h0000_3000, 32'h0, OBC_SZ_LONG, 1'b1);
    outs("after_wait", 3'b000);
    cpu.finish_insn();
    outs("after", 3'b100);
    clean();
    $display("test after done");
  endtask

  task automatic t_range();
    for (int p = 0; p < 2; p++) begin
      bus_op(1'b1, 7'h00, 32'h2 | (32'(p) << 3));
      bus_op(1'b1, ch(9 + 2 * p, 0), 32'h0000_0100);
      bus_op(1'b1, ch(9 + 2 * p, 4), 32'h0001_0003);
      bus_op(1'b1, ch(10 + 2 * p, 0), 32'h0000_01ff);
      bus_op(1'b1, ch(10 + 2 * p, 4), 32'h3);
      cpu.access(32'h0000_00ff, 32'h0, OBC_SZ_LONG, 1'b1);
      outs("below", 3'b000);
      cpu.access(32'h0000_0200, 32'h0, OBC_SZ_LONG, 1'b1);
      outs("above", 3'b000);
      cpu.access(32'h0000_01ff, 32'h0, OBC_SZ_LONG, 1'b1);
      outs("inside", 3'b110);
      clean();
    end
    $display("test range done");
  endtask

  task automatic t_time();
    bus_op(1'b1, 7'h00, 32'h3);
    bus_op(1'b1, 7'h02, 32'h4);
    for (int n = 7; n < 9; n++) begin
      bus_op(1'b1, ch(n, 0), 32'(n) << 8);
      bus_op(1'b1, ch(n, 4), 32'h3);
    end
    cpu.access(32'h0000_0700, 32'h0, OBC_SZ_LONG, 1'b1);
    repeat (4) @(posedge clk);
    cpu.access(32'h0000_0800, 32'h0, OBC_SZ_LONG, 1'b1);
    outs("time_quiet", 3'b000);
    @(posedge clk);
    #1;
    chk("irq_time", 32'h1, {31'h0, irq});
    bus_op(1'b0, 7'h01, 32'h0);
    chk("status_time", 32'h4, rdq);
    bus_op(1'b0, 7'h05, 32'h0);
    chk("timer_span", 32'h5, rdq);
    clean();
    $display("test time done");
  endtask

  task automatic t_seq();
    int s1[5] = '{5, 6, 4, 7, 8};
    int s2[4] = '{5, 6, 7, 8};
    bus_op(1'b1, 7'h00, 32'h45);
    for (int n = 4; n < 9; n++) begin
      bus_op(1'b1, ch(n, 0), 32'(n) << 8);
      bus_op(1'b1, ch(n, 4), (n == 8) ? 32'h0001_0003 : 32'h3);
    end
    foreach (s1[i]) cpu.access(32'(s1[i]) << 8, 32'h0, OBC_SZ_LONG, 1'b1);
    outs("seq_restart", 3'b000);
    foreach (s2[i]) cpu.access(32'(s2[i]) << 8, 32'h0, OBC_SZ_LONG, 1'b1);
    outs("seq_done", 3'b110);
    clean();
    $display("test seq done");
  endtask

  initial begin
    rst = 1'b1;
    avs_address = 7'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_before();
    t_trig();
    t_after();
    t_range();
    t_time();
    t_seq();
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule // onchip_break_comparator_tb
